// ---- adc_input_mux_model.sv ----
// Purpose: behavioural converter input multiplexer on the far side
// Assumes: source codes of analog_select_pkg::input_src_e, levels as bits
// Notes:   analog levels reduced to one bit; ground and temp read low
`timescale 1ns/100ps
`default_nettype none
module adc_input_mux_model (
	input  wire logic [3:0] pos_src,
	input  wire logic [3:0] neg_src,
	input  wire logic [7:0] pin_switch_even,
	input  wire logic [7:0] pin_switch_odd,
	input  wire logic [7:0] p3_level,
	input  wire logic       amp_level,
	input  wire logic       ref_level,
	output var  logic       pos_level,
	output var  logic       neg_level
);
	// ************************************************************
	// source picking
	// ************************************************************
	// closed switches short their pins together, so a high pin wins
	function automatic logic pick(input logic [3:0] src, input logic [7:0] ev,
		input logic [7:0] od, input logic [7:0] lv, input logic am, input logic rf);
		case (src)
			analog_select_pkg::src_even:   pick = |(ev & lv);
			analog_select_pkg::src_odd:    pick = |(od & lv);
			analog_select_pkg::src_amp:    pick = am;
			analog_select_pkg::src_ampref: pick = rf;
			default:                       pick = 1'b0;
		endcase
	endfunction
	// both converter inputs follow the routing codes at once
	always_comb begin
		pos_level = pick(pos_src, pin_switch_even, pin_switch_odd, p3_level, amp_level, ref_level);
		neg_level = pick(neg_src, pin_switch_even, pin_switch_odd, p3_level, amp_level, ref_level);
	end
endmodule
`default_nettype wire

// ---- analog_input_pin_select.sv ----
// Purpose: APB registers and port 3 pin routing onto the converter input multiplexer
// Assumes: pclk 20 MHz, presetn asynchronous active low, zero-wait APB
// Notes:   analog switches themselves sit outside; this drives their enables
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "analog_select_regs.svh"
module analog_input_pin_select (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic [7:0]  pin_switch_even,
	output var  logic [7:0]  pin_switch_odd,
	output var  logic        even_pin_channel_on,
	output var  logic        odd_pin_channel_on,
	output var  logic        amp_enable,
	output var  logic [3:0]  amplifier_gain_field,
	output var  logic [3:0]  pos_src,
	output var  logic [3:0]  neg_src,
	output var  logic        twos_comp
);
	logic [7:0] port3_analog_pin_enable_ff;
	logic [3:0] chan_config_ff;
	logic [3:0] chan_select_ff;
	logic [4:0] amp_control_ff;
	logic       setup_ok;
	logic       wr_en;
	logic [31:0] nxt_prdata;
	logic       nxt_err;
	// ************************************************************
	// helpers
	// ************************************************************
	// known offsets; anything else answers with pslverr
	function automatic logic addr_mapped(input logic [11:0] a);
		addr_mapped = (a == `OFS_PIN_ENABLE) || (a == `OFS_CHAN_CONFIG)
			|| (a == `OFS_CHAN_SELECT) || (a == `OFS_AMP_CONTROL)
			|| (a == `OFS_ROUTE_STATUS);
	endfunction
	// even/odd masks of enabled pins
	function automatic logic [7:0] pin_mask(input logic [7:0] en, input logic odd);
		pin_mask = en & (odd ? 8'hAA : 8'h55);
	endfunction
	assign setup_ok = psel && !penable;
	assign wr_en    = psel && penable && pwrite && pready && addr_mapped(paddr) && pstrb[0];
	// ************************************************************
	// apb handshake
	// ************************************************************
	// ready answers in the access phase: one cycle per transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_ok;
		end
	end
	// read data and error prepared in setup, presented with pready
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		nxt_err    = !addr_mapped(paddr);
		case (paddr)
			`OFS_PIN_ENABLE:   nxt_prdata = {24'h00_0000, port3_analog_pin_enable_ff};
			`OFS_CHAN_CONFIG:  nxt_prdata = {28'h000_0000, chan_config_ff};
			`OFS_CHAN_SELECT:  nxt_prdata = {28'h000_0000, chan_select_ff};
			`OFS_AMP_CONTROL:  nxt_prdata = {24'h00_0000, amp_control_ff[4], 3'h0,
				amp_control_ff[`AMP_GAIN_MSB:0]};
			`OFS_ROUTE_STATUS: nxt_prdata = {21'h00_0000, twos_comp, neg_src, pos_src,
				odd_pin_channel_on, even_pin_channel_on};
			default:           nxt_prdata = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup_ok) begin
			prdata  <= pwrite ? 32'h0000_0000 : nxt_prdata;
			pslverr <= nxt_err;
		end else begin
			pslverr <= 1'b0;
		end
	end
	// ************************************************************
	// registers
	// ************************************************************
	// pin enable byte: one bit per port 3 pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port3_analog_pin_enable_ff <= `RST_PIN_ENABLE;
		end else if (wr_en && paddr == `OFS_PIN_ENABLE) begin
			port3_analog_pin_enable_ff <= pwdata[7:0]; // [R1]
		end
	end
	// pair configuration bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_config_ff <= `RST_CHAN_CONFIG;
		end else if (wr_en && paddr == `OFS_CHAN_CONFIG) begin
			chan_config_ff <= pwdata[3:0];
		end
	end
	// channel select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_select_ff <= `RST_CHAN_SELECT;
		end else if (wr_en && paddr == `OFS_CHAN_SELECT) begin
			chan_select_ff <= pwdata[3:0];
		end
	end
	// amplifier enable and gain; bits 6-4 reserved, read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			amp_control_ff <= `RST_AMP_CONTROL;
		end else if (wr_en && paddr == `OFS_AMP_CONTROL) begin
			amp_control_ff <= {pwdata[`AMP_ENABLE_BIT], pwdata[`AMP_GAIN_MSB:0]}; // [R6]
		end
	end
	// ************************************************************
	// pin switches
	// ************************************************************
	// switch enables registered so the outputs come from flops; wired-OR is the shared node
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_switch_even     <= 8'h00;
			pin_switch_odd      <= 8'h00;
			even_pin_channel_on <= 1'b0;
			odd_pin_channel_on  <= 1'b0;
			amp_enable          <= 1'b0;
			amplifier_gain_field <= `GAIN_UNITY;
		end else begin
			pin_switch_even     <= pin_mask(port3_analog_pin_enable_ff, 1'b0); // [R2] [R3]
			pin_switch_odd      <= pin_mask(port3_analog_pin_enable_ff, 1'b1); // [R2] [R3]
			even_pin_channel_on <= |pin_mask(port3_analog_pin_enable_ff, 1'b0); // [R3]
			odd_pin_channel_on  <= |pin_mask(port3_analog_pin_enable_ff, 1'b1); // [R3]
			amp_enable          <= amp_control_ff[4];
			amplifier_gain_field <= amp_control_ff[`AMP_GAIN_MSB:0]; // [R6]
		end
	end
	// ************************************************************
	// converter input routing
	// ************************************************************
	route_decode u_route (
		.pclk        (pclk),
		.presetn     (presetn),
		.chan_select (chan_select_ff),
		.chan_config (chan_config_ff),
		.pos_src     (pos_src),
		.neg_src     (neg_src),
		.twos_comp   (twos_comp)
	);
	// ************************************************************
	// checks
	// ************************************************************
	property p_pin_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == `OFS_PIN_ENABLE) |=> (port3_analog_pin_enable_ff == $past(pwdata[7:0]));
	endproperty
	a_pin_write: assert property (p_pin_write) else $error("pin enable not stored"); // [R1]
	property p_wired_or;
		@(posedge pclk) disable iff (!presetn)
		##1 (pin_switch_even | pin_switch_odd) == $past(port3_analog_pin_enable_ff);
	endproperty
	a_wired_or: assert property (p_wired_or) else $error("pin switches lost a pin"); // [R2]
	property p_split;
		@(posedge pclk) disable iff (!presetn)
		((pin_switch_even & 8'hAA) == 8'h00) && ((pin_switch_odd & 8'h55) == 8'h00);
	endproperty
	a_split: assert property (p_split) else $error("pin on wrong channel"); // [R3]
	property p_odd_on;
		@(posedge pclk) disable iff (!presetn)
		odd_pin_channel_on == (pin_switch_odd != 8'h00);
	endproperty
	a_odd_on: assert property (p_odd_on) else $error("odd channel flag wrong"); // [R3]
	property p_gain;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == `OFS_AMP_CONTROL)
			|=> ##1 (amplifier_gain_field == $past(pwdata[3:0], 2));
	endproperty
	a_gain: assert property (p_gain) else $error("gain field not applied"); // [R6]
	property p_ready;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	// an unmapped place answers with an error and no data
	property p_unmapped_err;
		@(posedge pclk) disable iff (!presetn)
		(setup_ok && !addr_mapped(paddr)) |=> pready && pslverr && (prdata == 32'h0000_0000);
	endproperty
	a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped place not refused");
	// a write with its low strobe off leaves the enables alone
	property p_strobe_off;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready && pwrite && !pstrb[0]) |=> $stable(port3_analog_pin_enable_ff);
	endproperty
	a_strobe_off: assert property (p_strobe_off) else $error("write without strobe landed"); // [R1]
	property p_even_on;
		@(posedge pclk) disable iff (!presetn)
		even_pin_channel_on == (pin_switch_even != 8'h00);
	endproperty
	a_even_on: assert property (p_even_on) else $error("even channel flag wrong"); // [R3]
	// enable bit follows the write two edges on, like the gain
	property p_amp_on;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == `OFS_AMP_CONTROL)
			|=> ##1 (amp_enable == $past(pwdata[`AMP_ENABLE_BIT], 2));
	endproperty
	a_amp_on: assert property (p_amp_on) else $error("amplifier enable not applied");
	// ready is a single-cycle pulse, so a held request cannot write twice
	property p_ready_pulse;
		@(posedge pclk) disable iff (!presetn)
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held past one cycle");
endmodule
`default_nettype wire

// ---- analog_select_pkg.sv ----
// Purpose: types shared by the analog input pin select
// Assumes: constants live in analog_select_regs.svh
// Notes:   source codes for the converter positive and negative inputs
package analog_select_pkg;
	typedef enum logic [3:0] {
		src_none  = 4'h0,
		src_ain0  = 4'h1,
		src_ain1  = 4'h2,
		src_ain2  = 4'h3,
		src_ain3  = 4'h4,
		src_amp   = 4'h5,
		src_ampref = 4'h6,
		src_ground = 4'h7,
		src_even  = 4'h8,
		src_odd   = 4'h9,
		src_temp  = 4'hA
	} input_src_e;
endpackage

// ---- analog_select_regs.svh ----
// Purpose: register offsets, fields, resets and codes for the analog input pin select
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   the package holds the types only
// How it works
// [R1] eight enable bits, bit n set selects port 3 pin n as analog source
// [R2] any number of bits may be set; even and odd pins wired-OR together
// [R3] even channel carries enabled even pins, odd channel the enabled odd pins
// [R4] amplifier channel chosen routes amplifier output to converter positive input
// [R5] amplifier differential mode routes amplifier reference to converter negative input
// [R6] amplifier gain field of the amplifier control register picks output-stage gain
// [R7] any differential channel delivers its result word in two's complement
`ifndef ANALOG_SELECT_REGS_SVH
`define ANALOG_SELECT_REGS_SVH
// ************************************************************
// register byte offsets
// ************************************************************
`define OFS_PIN_ENABLE   12'h000
`define OFS_CHAN_CONFIG  12'h004
`define OFS_CHAN_SELECT  12'h008
`define OFS_AMP_CONTROL  12'h00C
`define OFS_ROUTE_STATUS 12'h010
// ************************************************************
// reset values and field layout
// ************************************************************
`define RST_PIN_ENABLE   8'h00
`define RST_CHAN_CONFIG  4'h0
`define RST_CHAN_SELECT  4'h0
`define RST_AMP_CONTROL  5'h00
`define CFG_PAIR01_BIT   0
`define CFG_PAIR23_BIT   1
`define CFG_AMP_DIFF_BIT 2
`define CFG_PORT3_PAIR_BIT 3
`define AMP_ENABLE_BIT   7
`define AMP_GAIN_MSB     3
`define GAIN_UNITY       4'h0
// ************************************************************
// channel select codes
// ************************************************************
`define SEL_AIN0         4'h0
`define SEL_AIN1         4'h1
`define SEL_AIN2         4'h2
`define SEL_AIN3         4'h3
`define SEL_AMP          4'h4
`define SEL_GROUND       4'h5
`define SEL_EVEN         4'h6
`define SEL_ODD          4'h7
`define SEL_TEMP_BIT     3
`endif

// ---- route_decode.sv ----
// Purpose: converts channel select and pair configuration into converter input routing
// Assumes: inputs are registers on pclk; result registered
// Notes:   one cycle from configuration change to routing change
`timescale 1ns/100ps
`default_nettype none
`include "analog_select_regs.svh"
module route_decode (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] chan_select,
	input  wire logic [3:0] chan_config,
	output var  logic [3:0] pos_src,
	output var  logic [3:0] neg_src,
	output var  logic       twos_comp
);
	logic [3:0] nxt_pos;
	logic [3:0] nxt_neg;
	logic       nxt_diff;
	// ************************************************************
	// decode
	// ************************************************************
	// pair members share one setting; the low member is the positive side
	always_comb begin
		nxt_pos  = analog_select_pkg::src_none;
		nxt_neg  = analog_select_pkg::src_ground;
		nxt_diff = 1'b0;
		if (chan_select[`SEL_TEMP_BIT]) begin
			nxt_pos = analog_select_pkg::src_temp;
		end else begin
			case (chan_select)
				`SEL_AIN0, `SEL_AIN1: begin
					if (chan_config[`CFG_PAIR01_BIT]) begin
						nxt_pos  = analog_select_pkg::src_ain0;
						nxt_neg  = analog_select_pkg::src_ain1;
						nxt_diff = 1'b1;
					end else begin
						nxt_pos = (chan_select == `SEL_AIN0) ? analog_select_pkg::src_ain0
							: analog_select_pkg::src_ain1;
					end
				end
				`SEL_AIN2, `SEL_AIN3: begin
					if (chan_config[`CFG_PAIR23_BIT]) begin
						nxt_pos  = analog_select_pkg::src_ain2;
						nxt_neg  = analog_select_pkg::src_ain3;
						nxt_diff = 1'b1;
					end else begin
						nxt_pos = (chan_select == `SEL_AIN2) ? analog_select_pkg::src_ain2
							: analog_select_pkg::src_ain3;
					end
				end
				`SEL_AMP, `SEL_GROUND: begin
					nxt_pos = analog_select_pkg::src_amp; // [R4]
					if (chan_config[`CFG_AMP_DIFF_BIT]) begin
						nxt_neg  = analog_select_pkg::src_ampref; // [R5]
						nxt_diff = 1'b1; // [R7]
					end else if (chan_select == `SEL_GROUND) begin
						nxt_pos = analog_select_pkg::src_ground;
					end
				end
				`SEL_EVEN, `SEL_ODD: begin
					if (chan_config[`CFG_PORT3_PAIR_BIT]) begin
						nxt_pos  = analog_select_pkg::src_even; // [R3]
						nxt_neg  = analog_select_pkg::src_odd;
						nxt_diff = 1'b1; // [R7]
					end else begin
						nxt_pos = (chan_select == `SEL_EVEN) ? analog_select_pkg::src_even
							: analog_select_pkg::src_odd; // [R3]
					end
				end
				default: begin
					nxt_pos = analog_select_pkg::src_none;
				end
			endcase
		end
	end
	// registered routing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_src   <= analog_select_pkg::src_ain0;
			neg_src   <= analog_select_pkg::src_ground;
			twos_comp <= 1'b0;
		end else begin
			pos_src   <= nxt_pos;
			neg_src   <= nxt_neg;
			twos_comp <= nxt_diff;
		end
	end
	// ************************************************************
	// checks
	// ************************************************************
	property p_amp_pos;
		@(posedge pclk) disable iff (!presetn)
		(chan_select == `SEL_AMP) |=> (pos_src == analog_select_pkg::src_amp);
	endproperty
	a_amp_pos: assert property (p_amp_pos) else $error("amp not on positive input"); // [R4]
	property p_amp_ref;
		@(posedge pclk) disable iff (!presetn)
		(chan_select == `SEL_AMP && chan_config[`CFG_AMP_DIFF_BIT])
			|=> (neg_src == analog_select_pkg::src_ampref) && twos_comp;
	endproperty
	a_amp_ref: assert property (p_amp_ref) else $error("amp reference not on negative"); // [R5]
	property p_diff_twos;
		@(posedge pclk) disable iff (!presetn)
		twos_comp |-> (neg_src != analog_select_pkg::src_ground);
	endproperty
	a_diff_twos: assert property (p_diff_twos) else $error("two's complement without pair"); // [R7]
	property p_even_chan;
		@(posedge pclk) disable iff (!presetn)
		(chan_select == `SEL_EVEN && !chan_config[`CFG_PORT3_PAIR_BIT])
			|=> (pos_src == analog_select_pkg::src_even) && !twos_comp;
	endproperty
	a_even_chan: assert property (p_even_chan) else $error("even channel misrouted"); // [R3]
endmodule
`default_nettype wire

// ---- tb.sv ----
// Purpose: self-checking bench for the analog input pin select
// Assumes: zero-wait APB slave, routing settles within two edges
// Notes:   pin levels drive the far-side model, not the design
`timescale 1ns/100ps
`default_nettype none
`include "analog_select_regs.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic [3:0]  pstrb = 4'hF, gain, pos_src, neg_src;
	logic        pready, pslverr, erv, even_on, odd_on, amp_en, twos_comp;
	logic [7:0]  pin_switch_even, pin_switch_odd, p3_level = 8'h00, v;
	logic        amp_level = 1'b0, ref_level = 1'b0, pos_level, neg_level;
	int          errors = 0, total_checks = 0, cycles = 0;
	always #25 pclk = ~pclk;
	analog_input_pin_select i_analog_input_pin_select (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_switch_even(pin_switch_even), .pin_switch_odd(pin_switch_odd),
		.even_pin_channel_on(even_on), .odd_pin_channel_on(odd_on), .amp_enable(amp_en),
		.amplifier_gain_field(gain), .pos_src(pos_src), .neg_src(neg_src),
		.twos_comp(twos_comp));
	adc_input_mux_model i_adc_input_mux_model (.pos_src(pos_src), .neg_src(neg_src),
		.pin_switch_even(pin_switch_even), .pin_switch_odd(pin_switch_odd),
		.p3_level(p3_level), .amp_level(amp_level), .ref_level(ref_level),
		.pos_level(pos_level), .neg_level(neg_level));
	// ************************************************************
	// closing and hang guard
	// ************************************************************
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// the whole run is a few hundred cycles; ceiling well above that
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("CHECK FAILED t=%0t run timeout", $time);
			complete_run();
		end
	end
	// ************************************************************
	// bus tasks
	// ************************************************************
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdv = prdata;
		erv = pslverr;
		if (n >= 50) begin
			errors++;
			$display("CHECK FAILED t=%0t no pready", $time);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hF);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0, 4'h0);
		`CHK(rdv, e)
		`CHK(erv, ee)
	endtask
	// routing lags the write by up to two edges
	task automatic settle();
		repeat (2) @(posedge pclk);
		#1;
	endtask
	task automatic pins_chk(input logic [7:0] x);
		wr(`OFS_PIN_ENABLE, {24'h0, x});
		settle();
		`CHK(pin_switch_even, x & 8'h55)
		`CHK(pin_switch_odd, x & 8'hAA)
		`CHK({even_on, odd_on}, {|(x & 8'h55), |(x & 8'hAA)})
		rd_chk(`OFS_PIN_ENABLE, {24'h0, x}, 1'b0);
	endtask
	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// reset state
		rd_chk(`OFS_PIN_ENABLE, 32'h0, 1'b0);
		rd_chk(`OFS_ROUTE_STATUS, 32'h0000_01C4, 1'b0);
		$display("test reset done");
		// each single pin, then mixed sets
		for (int n = 0; n < 8; n++) begin
			v = 8'h01 << n;
			pins_chk(v);
		end
		pins_chk(8'hFF);
		pins_chk(8'h5A);
		$display("test pin enables done");
		// wired-OR onto the even and odd channels
		pins_chk(8'h1C);
		wr(`OFS_CHAN_SELECT, {28'h0, `SEL_EVEN});
		@(posedge pclk) p3_level <= 8'h05;
		settle();
		`CHK(pos_src, analog_select_pkg::src_even)
		`CHK(pos_level, 1'b1)
		@(posedge pclk) p3_level <= 8'hEB;
		settle();
		`CHK(pos_level, 1'b0)
		wr(`OFS_CHAN_CONFIG, 32'h8);
		settle();
		`CHK({neg_src, twos_comp}, {analog_select_pkg::src_odd, 1'b1})
		`CHK(neg_level, 1'b1)
		$display("test port channels done");
		// amplifier single-ended, then differential
		wr(`OFS_CHAN_CONFIG, 32'h0);
		wr(`OFS_CHAN_SELECT, {28'h0, `SEL_AMP});
		@(posedge pclk) amp_level <= 1'b1;
		settle();
		`CHK({pos_src, neg_src}, {analog_select_pkg::src_amp, analog_select_pkg::src_ground})
		`CHK({pos_level, twos_comp}, 2'b10)
		@(posedge pclk) ref_level <= 1'b1;
		wr(`OFS_CHAN_CONFIG, 32'h4);
		settle();
		`CHK(neg_src, analog_select_pkg::src_ampref)
		`CHK({neg_level, twos_comp}, 2'b11)
		$display("test amplifier done");
		// gain field, reserved bits, ignored strobe, unmapped place
		wr(`OFS_AMP_CONTROL, 32'hFF);
		settle();
		`CHK({amp_en, gain}, 5'h1F)
		rd_chk(`OFS_AMP_CONTROL, 32'h8F, 1'b0);
		apb(1'b1, `OFS_AMP_CONTROL, 32'h03, 4'h0);
		rd_chk(`OFS_AMP_CONTROL, 32'h8F, 1'b0);
		wr(`OFS_AMP_CONTROL, {24'h0, 4'h0, `GAIN_UNITY});
		settle();
		`CHK({amp_en, gain}, 5'h00)
		apb(1'b1, 12'h020, 32'hFF, 4'hF);
		`CHK(erv, 1'b1)
		rd_chk(12'h020, 32'h0, 1'b1);
		$display("test gain and errors done");
		// pairs, ground and temperature selects
		wr(`OFS_CHAN_CONFIG, 32'h3);
		wr(`OFS_CHAN_SELECT, {28'h0, `SEL_AIN3});
		settle();
		`CHK({pos_src, twos_comp}, {analog_select_pkg::src_ain2, 1'b1})
		`CHK(neg_src, analog_select_pkg::src_ain3)
		wr(`OFS_CHAN_SELECT, {28'h0, `SEL_AIN0});
		settle();
		`CHK({pos_src, neg_src}, {analog_select_pkg::src_ain0, analog_select_pkg::src_ain1})
		wr(`OFS_CHAN_CONFIG, 32'h0);
		wr(`OFS_CHAN_SELECT, {28'h0, `SEL_GROUND});
		settle();
		`CHK({pos_src, twos_comp}, {analog_select_pkg::src_ground, 1'b0})
		wr(`OFS_CHAN_SELECT, 32'h8);
		settle();
		`CHK(pos_src, analog_select_pkg::src_temp)
		$display("test selects done");
		// reset in mid-run returns enables and routing to idle
		@(posedge pclk) presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(`OFS_PIN_ENABLE, 32'h0, 1'b0);
		`CHK({pin_switch_even, pin_switch_odd}, 16'h0000)
		`CHK(pos_src, analog_select_pkg::src_ain0)
		$display("test mid-run reset done");
		complete_run();
	end
endmodule
`default_nettype wire
